//--- rtl/adcc_pkg.sv
// Shared constants and types for the converter control block
package adcc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LT_LO  = 8'hC6;
  localparam logic [7:0] ADDR_LT_HI  = 8'hC7;
  localparam logic [7:0] ADDR_GT_LO  = 8'hC4;
  localparam logic [7:0] ADDR_GT_HI  = 8'hC5;
  localparam logic [7:0] ADDR_RES_LO = 8'hBE;
  localparam logic [7:0] ADDR_RES_HI = 8'hBF;
  localparam logic [7:0] ADDR_CFG    = 8'hBC;
  localparam logic [7:0] ADDR_MUX    = 8'hBB;
  localparam logic [7:0] ADDR_DIFF   = 8'hBA;
  localparam logic [7:0] ADDR_CTL    = 8'hE8;
  localparam logic [7:0] ADDR_IE     = 8'hE6;
  localparam logic [7:0] RST_BYTE    = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_LJ   = 0;
  localparam int CTL_WIN  = 1;
  localparam int CTL_DONE = 2;
  localparam int CTL_BUSY = 3;
  localparam int CTL_SMLO = 4;
  localparam int CTL_SMHI = 5;
  localparam int CTL_TM   = 6;
  localparam int CTL_EN   = 7;
  localparam int CFG_SCLO = 0;
  localparam int CFG_SCHI = 2;
  localparam int CFG_GNLO = 3;
  localparam int CFG_GNHI = 5;
  localparam int IE_DONE  = 0;
  localparam int IE_WIN   = 1;

  // ----------------------------------------------------------------
  // Converter constants and timing
  // ----------------------------------------------------------------
  localparam logic [11:0] SAR_MSB   = 12'h800;
  localparam logic [3:0]  IDX_TOP   = 4'hB;
  localparam logic [3:0]  IDX_LOW12 = 4'h0;
  localparam logic [3:0]  IDX_LOW10 = 4'h2;
  localparam logic [1:0]  TRACK_CLKS = 2'h3;
  localparam logic [2:0]  SCALE_MAX = 3'h4;
  localparam int CLK_HZ       = 250000000;
  localparam int MAX_RATE_SPS = 100000;
  localparam int MIN_CONV_CYC = (CLK_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
  localparam logic [11:0] HOLDOFF_INIT = 12'(MIN_CONV_CYC - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCC_SRC_SW  = 2'b00,
    ADCC_SRC_T3  = 2'b01,
    ADCC_SRC_EXT = 2'b10,
    ADCC_SRC_T2  = 2'b11
  } adcc_start_e;

  typedef enum logic [1:0] {
    ADCC_IDLE  = 2'b00,
    ADCC_TRACK = 2'b01,
    ADCC_CONV  = 2'b10
  } adcc_state_e;

endpackage

//--- rtl/adcc_clk_div.sv
// Conversion clock enable divider
module adcc_clk_div (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Divide select and enable out
  input  wire logic [2:0] scale,
  output logic            tick_r
);

  logic [3:0] cnt_r;
  logic [3:0] limit;
  logic       wrap;

  // Scale 0 gives every cycle, codes past the top clamp to sixteen
  assign limit = (scale >= adcc_pkg::SCALE_MAX) ? 4'hF
               : 4'((5'h01 << scale) - 5'h01);
  assign wrap  = (cnt_r >= limit);

  // Free running count and one-cycle enable
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_r  <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= wrap ? 4'h0 : cnt_r + 4'h1;
      tick_r <= wrap;
    end
  end

endmodule

//--- rtl/adcc_conv_ctrl.sv
// Successive approximation converter control, registers and window detect
// Function
// - Conversion clock from system clock, divided by 1, 2, 4, 8 or 16.
// - Start from software busy write, timer 3, external rising edge, timer 2.
// - Busy stays high for the whole conversion, low after.
// - Busy falling sets done flag and raises enabled interrupt.
// - Result byte pair left or right justified by justify bit.
// - Default track mode tracks always except during conversion.
// - Low-power mode with internal sources tracks three conversion clocks first.
// - Low-power mode with external start tracks only while input low.
// - Tracking disabled during chip standby or sleep.
// - Every result compared with limits, window flag and enabled interrupt raised on a hit.
// - Window flag may mean inside or outside the range.
// - Window flag readable so software can poll it.
// - Limit bytes separately writable, read/write, reset to zero.
// - Controller may shut converter down to save power.
// - Nine-way input select, one temperature sensor, eight external.
// - Each external pair single-ended or differential.
// - Amplifier gain 0.5 to 16 in power-of-two steps.
// - 10- or 12-bit result latched only at completion.
// - Conversion rate never above 100 thousand samples per second.
module adcc_conv_ctrl (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  // Start sources
  input  wire logic        timer2_ovf,
  input  wire logic        timer3_ovf,
  input  wire logic        ext_conv_start,
  // Chip state and variant
  input  wire logic        chip_standby,
  input  wire logic        res_is_10bit,
  // Analog side
  input  wire logic        sar_cmp,
  output logic      [11:0] dac_code,
  output logic             track_en,
  output logic             adc_powered,
  output logic      [3:0]  amux_sel,
  output logic      [3:0]  amux_diff,
  output logic      [2:0]  pga_gain,
  // Interrupt requests
  output logic             irq_done,
  output logic             irq_window
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  ctl_r, cfg_r, mux_r, diff_r, ie_r;
  logic [7:0]  gt_lo_r, gt_hi_r, lt_lo_r, lt_hi_r;
  logic [15:0] res_r;
  logic [7:0]  rdata_r;
  logic        irq_done_r, irq_win_r, track_r;
  logic        ext_d_r;
  logic [11:0] code_r, code_nxt;
  logic [3:0]  idx_r;
  logic [1:0]  trk_cnt_r;
  logic [11:0] holdoff_r;
  adcc_pkg::adcc_state_e st_r, st_nxt;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic wr_ctl, wr_cfg, wr_mux, wr_diff, wr_ie;
  logic wr_gtl, wr_gth, wr_ltl, wr_lth;
  assign wr_ctl  = sfr_wr && (sfr_addr == adcc_pkg::ADDR_CTL);
  assign wr_cfg  = sfr_wr && (sfr_addr == adcc_pkg::ADDR_CFG);
  assign wr_mux  = sfr_wr && (sfr_addr == adcc_pkg::ADDR_MUX);
  assign wr_diff = sfr_wr && (sfr_addr == adcc_pkg::ADDR_DIFF);
  assign wr_ie   = sfr_wr && (sfr_addr == adcc_pkg::ADDR_IE);
  assign wr_gtl  = sfr_wr && (sfr_addr == adcc_pkg::ADDR_GT_LO);
  assign wr_gth  = sfr_wr && (sfr_addr == adcc_pkg::ADDR_GT_HI);
  assign wr_ltl  = sfr_wr && (sfr_addr == adcc_pkg::ADDR_LT_LO);
  assign wr_lth  = sfr_wr && (sfr_addr == adcc_pkg::ADDR_LT_HI);

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  logic        en, ljust, tmode, busy, done_flag, win_flag;
  logic [1:0]  smode;
  logic [2:0]  scale;
  assign en        = ctl_r[adcc_pkg::CTL_EN];
  assign ljust     = ctl_r[adcc_pkg::CTL_LJ];
  assign tmode     = ctl_r[adcc_pkg::CTL_TM];
  assign busy      = ctl_r[adcc_pkg::CTL_BUSY];
  assign done_flag = ctl_r[adcc_pkg::CTL_DONE];
  assign win_flag  = ctl_r[adcc_pkg::CTL_WIN];
  assign smode     = ctl_r[adcc_pkg::CTL_SMHI:adcc_pkg::CTL_SMLO];
  assign scale     = cfg_r[adcc_pkg::CFG_SCHI:adcc_pkg::CFG_SCLO];

  // ----------------------------------------------------------------
  // Conversion clock enable
  // ----------------------------------------------------------------
  logic tick;
  adcc_clk_div u_div (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .scale    (scale),
    .tick_r   (tick)
  );

  // ----------------------------------------------------------------
  // Start selection
  // ----------------------------------------------------------------
  logic sw_start, ext_rise, start_req, accept, ext_src;
  assign sw_start = wr_ctl && sfr_wdata[adcc_pkg::CTL_BUSY];
  // Input taken as synchronous, one flop gives the edge
  assign ext_rise = ext_conv_start && !ext_d_r;
  assign ext_src  = (smode == adcc_pkg::ADCC_SRC_EXT);
  assign start_req = (smode == adcc_pkg::ADCC_SRC_SW)  ? sw_start
                   : (smode == adcc_pkg::ADCC_SRC_T3)  ? timer3_ovf
                   : (smode == adcc_pkg::ADCC_SRC_EXT) ? ext_rise
                   : timer2_ovf;
  // holdoff keeps starts at least 10 us apart
  // a shut-down converter takes no start
  assign accept = start_req && en && (st_r == adcc_pkg::ADCC_IDLE)
               && (holdoff_r == 12'h000);

  // ----------------------------------------------------------------
  // Successive approximation step
  // ----------------------------------------------------------------
  logic [3:0] idx_low;
  logic       sar_step, finish;
  // variant width sets the last bit tried
  assign idx_low  = res_is_10bit ? adcc_pkg::IDX_LOW10 : adcc_pkg::IDX_LOW12;
  assign sar_step = (st_r == adcc_pkg::ADCC_CONV) && tick;
  assign finish   = sar_step && (idx_r == idx_low);

  // Keep tried bit per comparator, then try the next one down
  always_comb begin
    code_nxt = code_r;
    if (sar_step) begin
      code_nxt[idx_r] = sar_cmp;
      if (idx_r != idx_low) begin
        code_nxt[idx_r - 4'h1] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result formatting and window compare
  // ----------------------------------------------------------------
  logic [15:0] res_fmt, gt_w, lt_w;
  logic        win_hit;
  assign res_fmt = res_is_10bit
                 ? (ljust ? {code_nxt[11:2], 6'h00} : {6'h00, code_nxt[11:2]})
                 : (ljust ? {code_nxt, 4'h0} : {4'h0, code_nxt});
  assign gt_w = {gt_hi_r, gt_lo_r};
  assign lt_w = {lt_hi_r, lt_lo_r};
  // inside when the less-than limit is above the greater-than limit, outside otherwise
  // limit order picks inside or outside
  assign win_hit = (lt_w > gt_w) ? ((res_fmt > gt_w) && (res_fmt < lt_w))
                                 : ((res_fmt > gt_w) || (res_fmt < lt_w));

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Low-power mode with internal sources tracks first
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      adcc_pkg::ADCC_IDLE: begin
        if (accept) begin
          st_nxt = (tmode && !ext_src) ? adcc_pkg::ADCC_TRACK
                                       : adcc_pkg::ADCC_CONV;
        end
      end
      adcc_pkg::ADCC_TRACK: begin
        if (tick && (trk_cnt_r == adcc_pkg::TRACK_CLKS - 2'h1)) begin
          st_nxt = adcc_pkg::ADCC_CONV;
        end
      end
      adcc_pkg::ADCC_CONV: begin
        if (finish) begin
          st_nxt = adcc_pkg::ADCC_IDLE;
        end
      end
      default: st_nxt = adcc_pkg::ADCC_IDLE;
    endcase
  end

  // State, counters and edge memory
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r      <= adcc_pkg::ADCC_IDLE;
      ext_d_r   <= 1'b0;
      trk_cnt_r <= 2'h0;
      holdoff_r <= 12'h000;
    end else begin
      st_r      <= st_nxt;
      ext_d_r   <= ext_conv_start;
      // Tracking clocks counted only in the track state
      if (st_r != adcc_pkg::ADCC_TRACK) begin
        trk_cnt_r <= 2'h0;
      end else if (tick) begin
        trk_cnt_r <= trk_cnt_r + 2'h1;
      end
      if (accept) begin
        holdoff_r <= adcc_pkg::HOLDOFF_INIT;
      end else if (holdoff_r != 12'h000) begin
        holdoff_r <= holdoff_r - 12'h001;
      end
    end
  end

  // SAR code and bit index
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      code_r <= 12'h000;
      idx_r  <= adcc_pkg::IDX_TOP;
    end else if (accept) begin
      code_r <= adcc_pkg::SAR_MSB;
      idx_r  <= adcc_pkg::IDX_TOP;
    end else if (sar_step && !finish) begin
      code_r <= code_nxt;
      idx_r  <= idx_r - 4'h1;
    end else begin
      code_r <= code_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Control register with hardware flags
  // ----------------------------------------------------------------
  logic [7:0] ctl_nxt;
  // Hardware sets win over a software clear in the same cycle
  always_comb begin
    ctl_nxt = wr_ctl ? sfr_wdata : ctl_r;
    // busy follows the conversion, not the write
    ctl_nxt[adcc_pkg::CTL_BUSY] = (st_nxt != adcc_pkg::ADCC_IDLE);
    if (finish) begin
      ctl_nxt[adcc_pkg::CTL_DONE] = 1'b1;
    end
    // flag every result in the detect band
    if (finish && win_hit) begin
      ctl_nxt[adcc_pkg::CTL_WIN] = 1'b1;
    end
  end

  // window flag lives in a readable control bit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctl_r <= adcc_pkg::RST_BYTE;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Plain configuration registers
  // ----------------------------------------------------------------
  // each limit byte written on its own
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_r   <= adcc_pkg::RST_BYTE;
      mux_r   <= adcc_pkg::RST_BYTE;
      diff_r  <= adcc_pkg::RST_BYTE;
      ie_r    <= adcc_pkg::RST_BYTE;
      gt_lo_r <= adcc_pkg::RST_BYTE;
      gt_hi_r <= adcc_pkg::RST_BYTE;
      lt_lo_r <= adcc_pkg::RST_BYTE;
      lt_hi_r <= adcc_pkg::RST_BYTE;
    end else begin
      if (wr_cfg)  cfg_r   <= sfr_wdata;
      if (wr_mux)  mux_r   <= sfr_wdata;
      if (wr_diff) diff_r  <= sfr_wdata;
      if (wr_ie)   ie_r    <= sfr_wdata;
      if (wr_gtl)  gt_lo_r <= sfr_wdata;
      if (wr_gth)  gt_hi_r <= sfr_wdata;
      if (wr_ltl)  lt_lo_r <= sfr_wdata;
      if (wr_lth)  lt_hi_r <= sfr_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      res_r <= 16'h0000;
    end else if (finish) begin
      res_r <= res_fmt;
    end
  end

  // ----------------------------------------------------------------
  // Track-and-hold control
  // ----------------------------------------------------------------
  logic trk_want, trk_nxt;
  // external low-power mode tracks while input low
  assign trk_want = !tmode ? (st_r != adcc_pkg::ADCC_CONV)
                  : ext_src ? (!ext_conv_start && (st_r != adcc_pkg::ADCC_CONV))
                  : (st_r == adcc_pkg::ADCC_TRACK);
  assign trk_nxt = trk_want && en && !chip_standby;

  // Output flops for the analog side and interrupts
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      track_r    <= 1'b0;
      irq_done_r <= 1'b0;
      irq_win_r  <= 1'b0;
    end else begin
      track_r    <= trk_nxt;
      irq_done_r <= ctl_nxt[adcc_pkg::CTL_DONE] && ie_r[adcc_pkg::IE_DONE];
      irq_win_r  <= ctl_nxt[adcc_pkg::CTL_WIN] && ie_r[adcc_pkg::IE_WIN];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  assign rd_mux = (sfr_addr == adcc_pkg::ADDR_CTL)    ? ctl_r
                : (sfr_addr == adcc_pkg::ADDR_CFG)    ? cfg_r
                : (sfr_addr == adcc_pkg::ADDR_MUX)    ? mux_r
                : (sfr_addr == adcc_pkg::ADDR_DIFF)   ? diff_r
                : (sfr_addr == adcc_pkg::ADDR_IE)     ? ie_r
                : (sfr_addr == adcc_pkg::ADDR_GT_LO)  ? gt_lo_r
                : (sfr_addr == adcc_pkg::ADDR_GT_HI)  ? gt_hi_r
                : (sfr_addr == adcc_pkg::ADDR_LT_LO)  ? lt_lo_r
                : (sfr_addr == adcc_pkg::ADDR_LT_HI)  ? lt_hi_r
                : (sfr_addr == adcc_pkg::ADDR_RES_LO) ? res_r[7:0]
                : (sfr_addr == adcc_pkg::ADDR_RES_HI) ? res_r[15:8]
                : adcc_pkg::RST_BYTE;

  // Reads have no side effect, data held until the next read
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_r <= adcc_pkg::RST_BYTE;
    end else if (sfr_rd) begin
      rdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfr_rdata   = rdata_r;
  assign dac_code    = code_r;
  assign track_en    = track_r;
  assign adc_powered = ctl_r[adcc_pkg::CTL_EN];
  // channel 8 is the temperature sensor
  assign amux_sel    = mux_r[3:0];
  assign amux_diff   = diff_r[3:0];
  // code 0 is half, each step doubles
  assign pga_gain    = cfg_r[adcc_pkg::CFG_GNHI:adcc_pkg::CFG_GNLO];
  assign irq_done    = irq_done_r;
  assign irq_window  = irq_win_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_BUSY_HELD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_r != adcc_pkg::ADCC_IDLE) |-> busy) else $error("busy low mid conversion");
  AST_DONE_ON_FALL: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(busy) |-> done_flag) else $error("busy fell without done flag");
  AST_IRQ_CAUSE: assert property (@(posedge core_clk) disable iff (sys_rst)
    irq_done |-> ie_r[adcc_pkg::IE_DONE] || $past(ie_r[adcc_pkg::IE_DONE]))
    else $error("done interrupt while disabled");
  AST_DIV16: assert property (@(posedge core_clk) disable iff (sys_rst)
    (tick && scale == adcc_pkg::SCALE_MAX && $stable(scale)) |=> !tick [*8])
    else $error("divide by sixteen too fast");
  AST_TRACK_EXIT: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_r == adcc_pkg::ADCC_TRACK && tick && trk_cnt_r == 2'h2)
    |=> st_r == adcc_pkg::ADCC_CONV) else $error("track not three clocks");
  AST_IGNORE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_r != adcc_pkg::ADCC_IDLE && start_req) |=> holdoff_r != adcc_pkg::HOLDOFF_INIT)
    else $error("start taken mid conversion");
  AST_RATE: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept |=> !accept [*8]) else $error("starts too close");
  AST_RES_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
    !finish |=> $stable(res_r)) else $error("result moved outside completion");
  AST_WIN_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
    (finish && win_hit) |=> win_flag) else $error("window hit not flagged");
  AST_LJ_ZERO: assert property (@(posedge core_clk) disable iff (sys_rst)
    (finish && ljust && !wr_ctl) |=> res_r[3:0] == 4'h0)
    else $error("left justified low bits not zero");
  AST_STBY: assert property (@(posedge core_clk) disable iff (sys_rst)
    chip_standby |=> !track_en) else $error("tracking in standby");
  AST_EXT_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (tmode && ext_src && ext_conv_start && !wr_ctl) |=> !track_en)
    else $error("tracking while external start high");

  COV_SW_CONV: cover property (@(posedge core_clk) disable iff (sys_rst)
    accept && smode == adcc_pkg::ADCC_SRC_SW ##[1:300] finish);
  COV_TRACK: cover property (@(posedge core_clk) disable iff (sys_rst)
    st_r == adcc_pkg::ADCC_TRACK ##1 st_r == adcc_pkg::ADCC_CONV);
  COV_WIN: cover property (@(posedge core_clk) disable iff (sys_rst)
    finish && win_hit && (lt_w > gt_w));

endmodule

//--- verif/adcc_analog_model.sv
// Analog mux and track-and-hold model facing the converter control
module adcc_analog_model (
  // Converter side
  input  wire logic [3:0]  amux_sel,
  input  wire logic [11:0] dac_code,
  input  wire logic        track_en,
  // Comparator result
  output logic             sar_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Inputs 0..7 external, 8 temperature sensor
  localparam logic [11:0] VIN [9] = '{12'h123, 12'h456, 12'h789, 12'hABC,
    12'hFFF, 12'h000, 12'h800, 12'h7FF, 12'h5A5};
  logic [11:0] held_r = 12'h000;
  // nine-way select
  // Held sample only follows the input while tracking
  always @(amux_sel or track_en)
    if (track_en) held_r = (amux_sel > 4'h8) ? 12'h000 : VIN[amux_sel];
  // Trial code at or below the held level reads high
  assign sar_cmp = (held_r >= dac_code);
endmodule

//--- verif/adcc_conv_ctrl_test.sv
// Self-checking bench for the converter control block
module adcc_conv_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0]  ch;
    logic        lj;
    logic [15:0] gt;
    logic [15:0] lt;
    logic [15:0] res;
    logic        win;
  } adcc_row_s;
  // Channel, justify, limits, justified result, window flag
  localparam adcc_row_s ROWS [5] = '{
    '{4'h0, 1'b0, 16'h0100, 16'h0200, 16'h0123, 1'b1},
    '{4'h1, 1'b1, 16'h1000, 16'h2000, 16'h4560, 1'b0},
    '{4'h4, 1'b0, 16'h0800, 16'h0100, 16'h0FFF, 1'b1},
    '{4'h5, 1'b1, 16'h0000, 16'h0000, 16'h0000, 1'b0},
    '{4'h8, 1'b0, 16'h05A5, 16'h05A6, 16'h05A5, 1'b0}};
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic        timer2_ovf = 1'b0;
  logic        timer3_ovf = 1'b0;
  logic        ext_conv_start = 1'b0;
  logic        chip_standby = 1'b0;
  logic        res_is_10bit = 1'b0;
  logic [7:0]  sfr_rdata, rd_d, ctl_v;
  logic        sar_cmp, track_en, adc_powered, irq_done, irq_window;
  logic [11:0] dac_code;
  logic [3:0]  amux_sel, amux_diff;
  logic [2:0]  pga_gain;
  adcc_row_s   r;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cnt;
  adcc_conv_ctrl adcc_conv_ctrl_inst (.core_clk, .sys_rst, .sfr_addr, .sfr_wdata,
    .sfr_wr, .sfr_rd, .sfr_rdata, .timer2_ovf, .timer3_ovf, .ext_conv_start,
    .chip_standby, .res_is_10bit, .sar_cmp, .dac_code, .track_en, .adc_powered,
    .amux_sel, .amux_diff, .pga_gain, .irq_done, .irq_window);
  adcc_analog_model adcc_analog_model_inst (.amux_sel, .dac_code, .track_en, .sar_cmp);
  // 250 MHz clock
  always #2 core_clk = ~core_clk;
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One write strobe, one idle cycle after so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask
  // Read data is valid the cycle after the read edge
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    rd_d = sfr_rdata;
  endtask
  task automatic wait_done(input int lim);
    cnt = 0;
    while (irq_done !== 1'b1) begin
      @(negedge core_clk);
      cnt++;
      if (cnt > lim) begin
        miscompares++;
        $display("BAD irq_done expected 1 seen timeout");
        wrap_up();
      end
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    // Less-than limit bytes: reset to zero, then full read/write
    for (int k = 0; k < 2; k++) begin
      rd(adcc_pkg::ADDR_LT_LO + 8'(k));
      chk("lt_rst", 16'(rd_d), 16'h0000);
      wr(adcc_pkg::ADDR_LT_LO + 8'(k), 8'hFF);
      rd(adcc_pkg::ADDR_LT_LO + 8'(k));
      chk("lt_rw", 16'(rd_d), 16'h00FF);
    end
    rd(8'h00);
    chk("unmapped", 16'(rd_d), 16'h0000);
    chk("powered_rst", 16'(adc_powered), 16'h0000);
    wr(adcc_pkg::ADDR_IE, 8'h03);
    wr(adcc_pkg::ADDR_CFG, 8'h28);
    wr(adcc_pkg::ADDR_DIFF, 8'h0A);
    chk("gain", 16'(pga_gain), 16'h0005);
    chk("diff", 16'(amux_diff), 16'h000A);
    $display("register test finished");
    // Table rows, start source cycles through all four modes
    for (int i = 0; i < 5; i++) begin
      r = ROWS[i];
      ctl_v = {2'b10, 2'(i), 3'b000, r.lj};
      wr(adcc_pkg::ADDR_GT_LO, r.gt[7:0]);
      wr(adcc_pkg::ADDR_GT_HI, r.gt[15:8]);
      wr(adcc_pkg::ADDR_LT_LO, r.lt[7:0]);
      wr(adcc_pkg::ADDR_LT_HI, r.lt[15:8]);
      wr(adcc_pkg::ADDR_MUX, {4'h0, r.ch});
      wr(adcc_pkg::ADDR_CTL, ctl_v);
      chk("mux", 16'(amux_sel), 16'(r.ch));
      @(negedge core_clk);
      case (i % 4)
        0: wr(adcc_pkg::ADDR_CTL, ctl_v | 8'h08);
        1: timer3_ovf = 1'b1;
        2: ext_conv_start = 1'b1;
        default: timer2_ovf = 1'b1;
      endcase
      @(negedge core_clk);
      timer3_ovf = 1'b0;
      timer2_ovf = 1'b0;
      wait_done(100);
      rd(adcc_pkg::ADDR_RES_HI);
      chk("res_hi", 16'(rd_d), 16'(r.res[15:8]));
      rd(adcc_pkg::ADDR_RES_LO);
      chk("res_lo", 16'(rd_d), 16'(r.res[7:0]));
      rd(adcc_pkg::ADDR_CTL);
      chk("busy_done_win", 16'(rd_d[3:1]), 16'({2'b01, r.win}));
      chk("irq_window", 16'(irq_window), 16'(r.win));
      ext_conv_start = 1'b0;
      wr(adcc_pkg::ADDR_CTL, ctl_v);
      repeat (2) @(negedge core_clk);
      chk("irq_done_clr", 16'(irq_done), 16'h0000);
      repeat (2500) @(negedge core_clk);
      $display("row %0d finished", i);
    end
    // Divide by 16 with three tracking ticks; second start is dropped
    wr(adcc_pkg::ADDR_CFG, 8'h04);
    wr(adcc_pkg::ADDR_CTL, 8'hC0);
    wr(adcc_pkg::ADDR_CTL, 8'hC8);
    rd(adcc_pkg::ADDR_CTL);
    chk("busy_mid", 16'(rd_d[3]), 16'h0001);
    wr(adcc_pkg::ADDR_CTL, 8'hC8);
    wait_done(400);
    chk("conv_len", 16'(cnt > 200 && cnt < 260), 16'h0001);
    wr(adcc_pkg::ADDR_CTL, 8'h80);
    $display("scale test finished");
    // Standby stops tracking, shutdown blocks starts
    repeat (2) @(negedge core_clk);
    chk("track_idle", 16'(track_en), 16'h0001);
    chip_standby = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("track_sleep", 16'(track_en), 16'h0000);
    chip_standby = 1'b0;
    chk("powered", 16'(adc_powered), 16'h0001);
    wr(adcc_pkg::ADDR_CTL, 8'h00);
    repeat (2500) @(negedge core_clk);
    chk("powered_off", 16'(adc_powered), 16'h0000);
    wr(adcc_pkg::ADDR_CTL, 8'h08);
    rd(adcc_pkg::ADDR_CTL);
    chk("busy_off", 16'(rd_d[3]), 16'h0000);
    $display("power test finished");
    // low-power external mode tracks only while input low
    wr(adcc_pkg::ADDR_CTL, 8'hE0);
    ext_conv_start = 1'b1;
    wait_done(300);
    chk("track_ext_hi", 16'(track_en), 16'h0000);
    chk("dac_code", 16'(dac_code), 16'h05A5);
    ext_conv_start = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("track_ext_lo", 16'(track_en), 16'h0001);
    $display("external track test finished");
    // Mid-run reset while holdoff runs, then a 10-bit variant run
    sys_rst = 1'b1;
    res_is_10bit = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    rd(adcc_pkg::ADDR_LT_HI);
    chk("lt_hi_rst", 16'(rd_d), 16'h0000);
    chk("irq_pwr_rst", 16'({irq_done, irq_window, adc_powered}), 16'h0000);
    wr(adcc_pkg::ADDR_CTL, 8'h81);
    wr(adcc_pkg::ADDR_CTL, 8'h89);
    cnt = 0;
    do begin
      rd(adcc_pkg::ADDR_CTL);
      cnt++;
    end while (rd_d[2] !== 1'b1 && cnt < 50);
    chk("done_poll", 16'(rd_d[3:2]), 16'h0001);
    rd(adcc_pkg::ADDR_RES_HI);
    chk("res10_hi", 16'(rd_d), 16'h0012);
    rd(adcc_pkg::ADDR_RES_LO);
    chk("res10_lo", 16'(rd_d), 16'h0000);
    $display("reset and 10-bit test finished");
    wrap_up();
  end
endmodule
